// ---- design/oseq_params.svh ----
// offsets, field positions, reset values and timing counts of the output sequencer
`ifndef OSEQ_PARAMS_SVH
`define OSEQ_PARAMS_SVH
// register indices; byte address is four times the index
`define OSEQ_IDX_PROT   5'h00
`define OSEQ_IDX_THR    5'h01
`define OSEQ_IDX_TRK    5'h03
`define OSEQ_IDX_DON    5'h05
`define OSEQ_IDX_DOF    5'h06
`define OSEQ_IDX_VOS    5'h07
`define OSEQ_IDX_CLS    5'h08
`define OSEQ_IDX_DCL    5'h09
`define OSEQ_IDX_RUN    5'h15
`define OSEQ_IDX_ST     5'h16
// reset values
`define OSEQ_RST_VOS    9'h050
`define OSEQ_RST_CLS    16'h00FF
`define OSEQ_RST_PROT   10'h2AA
`define OSEQ_RST_THR    17'h05573
`define OSEQ_RST_DCL    8'hFF
`define OSEQ_RST_ST     7'h7F
// fault flag positions
`define OSEQ_F_OC       0
`define OSEQ_F_UV       1
`define OSEQ_F_OT       2
`define OSEQ_F_TR       3
`define OSEQ_F_OV       4
`define OSEQ_F_OTW      5
`define OSEQ_F_PG       6
// setpoint codes in 12.5 mV units
`define OSEQ_VOS_MIN    9'h028
`define OSEQ_VOS_MAX    9'h1B8
`define OSEQ_VOS_MID    9'h0A0
`define OSEQ_VOS_TOP    9'h1A8
// power good percentages
`define OSEQ_PGH_PCT    8'h6E
`define OSEQ_PGL_HI     8'h5F
`define OSEQ_PGL_LO     8'h5A
// restart interval
`define OSEQ_RESTART_MS 130
`define OSEQ_CLK_KHZ    25000
`define OSEQ_RESTART_CYC (`OSEQ_RESTART_MS * `OSEQ_CLK_KHZ)
`endif

// ---- design/oseq_pkg.sv ----
// types shared by the output sequencer modules
package oseq_pkg;
    typedef enum logic [6:0] {
        ST_OFF    = 7'h01,
        ST_ON_DLY = 7'h02,
        ST_RUP    = 7'h04,
        ST_STEADY = 7'h08,
        ST_OFF_DL = 7'h10,
        ST_RDN    = 7'h20,
        ST_FAULT  = 7'h40
    } oseq_state_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic       step;
    } oseq_div_t;

    typedef struct packed {
        oseq_state_t state;
        logic [4:0]  aw_idx;
        logic        aw_map;
        logic        aw_full;
        logic [31:0] wdat;
        logic [3:0]  wstb;
        logic        w_full;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [8:0]  output_setpoint_reg;
        logic [15:0] current_limit_reg;
        logic [15:0] turn_on_delay_reg;
        logic [15:0] turn_off_delay_reg;
        logic [15:0] trk;
        logic [9:0]  prot;
        logic [16:0] thr;
        logic [7:0]  dcl;
        logic        run;
        logic [6:0]  st;
        logic [15:0] cnt;
        logic [8:0]  ramp;
        logic [21:0] rst_cnt;
        logic [4:0]  trip;
        logic        cyc;
        logic [8:0]  vout;
        logic        sw_en;
        logic        ls_on;
        logic        pg_ok;
        logic [16:0] ov_l;
        logic [16:0] uv_l;
        logic [16:0] pgh_l;
        logic [16:0] pgl_l;
    } oseq_regs_t;
endpackage

// ---- design/oseq_step_div.sv ----
// ramp step timer: divides the master clock ticks into step pulses
`timescale 1ns/1ps
`default_nettype none
module oseq_step_div (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       clken,
    input  wire logic       run,
    input  wire logic       tick,
    input  wire logic [7:0] div,
    output logic            step
);
    oseq_pkg::oseq_div_t r, n;
    logic [7:0] lim;

    // a zero divisor is taken as one tick per step
    always_comb begin
        n = r;
        n.step = 1'b0;
        lim = (div == 8'h00) ? 8'h01 : div;
        if (!run) begin
            n.cnt = 8'h00;
        end else if (tick) begin
            if (r.cnt + 8'h01 >= lim) begin
                n.cnt = 8'h00;
                n.step = 1'b1;
            end else begin
                n.cnt = r.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else if (clken) begin
            r <= n;
        end
    end

    assign step = r.step;
endmodule
`default_nettype wire

// ---- design/oseq_core.sv ----
// output sequencing and protection controller with its AXI4-Lite register file
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "oseq_params.svh"
// Operation
// - setpoint quantised to 12.5, 25 or 50 mV by sub-range
// - output held off for turn-on delay after turn-on command
// - with falling slew, delay ends when output reaches zero, ramp included
// - without falling slew, delay ends by switching both switches off
// - ramp moves in 12.5 mV steps; slew sets step length only
// - step length derived by dividing the master clock ticks
// - every protection state is a flag in the fault flag register
// - voltage thresholds and power good limits track the active setpoint
// - each protection latching, non-latching or disabled by type register
// - non-latching protection retries every 130 ms through normal sequencing
// - latching stays off until 130 ms, condition gone, and clear or cycle
// - warnings never switch the output off, only flag it
// - thresholds come from current limit and threshold config registers
// - load regulation lowers output target as current rises
// - delays and slew rates come from their configuration registers
// - duty cycle limit only changes while the output is off
module oseq_core #(
    parameter int unsigned RESTART_CYC = `OSEQ_RESTART_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clken,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        master_tick,
    input  wire logic [4:0]  fault_cond,
    input  wire logic        otw_cond,
    input  wire logic        pg_cond,
    input  wire logic [7:0]  iout,
    output logic [8:0]       vout_code,
    output logic             switch_en,
    output logic             low_side_on,
    output logic             power_good,
    output logic [16:0]      ov_level,
    output logic [16:0]      uv_level,
    output logic [16:0]      pgh_level,
    output logic [16:0]      pgl_level,
    output logic [7:0]       oc_limit,
    output logic [7:0]       duty_limit
);
    oseq_pkg::oseq_regs_t rs, nx;
    logic        step;
    logic        div_run;
    logic [7:0]  div_val;
    logic [4:0]  active;
    logic [4:0]  enabled;
    logic [4:0]  nonlat;
    logic [4:0]  tripped;
    logic [31:0] mrg;
    logic [16:0] ramp_t;
    logic [15:0] droop;
    localparam logic [21:0] RST_LAST = 22'(RESTART_CYC - 1);

    // ***********************************************************
    // helpers
    // ***********************************************************
    // clamp and quantise a setpoint code to its sub-range resolution
    function automatic logic [8:0] quant(input logic [8:0] c);
        logic [8:0] v;
        v = (c < `OSEQ_VOS_MIN) ? `OSEQ_VOS_MIN : (c > `OSEQ_VOS_MAX) ? `OSEQ_VOS_MAX : c;
        if (v >= `OSEQ_VOS_TOP) begin
            v = {v[8:2], 2'b00};
        end else if (v > `OSEQ_VOS_MID) begin
            v = {v[8:1], 1'b0};
        end
        return v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        m = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return m;
    endfunction

    function automatic logic mapped(input logic [4:0] i);
        return i == `OSEQ_IDX_PROT || i == `OSEQ_IDX_THR || i == `OSEQ_IDX_TRK || i == `OSEQ_IDX_DON ||
               i == `OSEQ_IDX_DOF || i == `OSEQ_IDX_VOS || i == `OSEQ_IDX_CLS || i == `OSEQ_IDX_DCL ||
               i == `OSEQ_IDX_RUN || i == `OSEQ_IDX_ST;
    endfunction

    // per-protection type decode: 00 disabled, 01 latching, 10 non-latching
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_type
            assign enabled[g] = rs.prot[2*g +: 2] != 2'b00;
            assign nonlat[g]  = rs.prot[2*g +: 2] == 2'b10;
        end
    endgenerate

    // step timer runs only while ramping; rise or fall divisor picked by direction
    assign div_run = (rs.state == oseq_pkg::ST_RUP) || (rs.state == oseq_pkg::ST_RDN);
    assign div_val = (rs.state == oseq_pkg::ST_RDN) ? rs.trk[15:8] : rs.trk[7:0];

    oseq_step_div u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clken   (clken),
        .run     (div_run),
        .tick    (master_tick),
        .div     (div_val),
        .step    (step)
    );

    // ***********************************************************
    // next-state logic
    // ***********************************************************
    always_comb begin
        nx = rs;
        mrg = 32'h0;
        // undervoltage only counts in steady state, tracking only while ramping up
        active = 5'b10101;
        active[`OSEQ_F_UV] = rs.state == oseq_pkg::ST_STEADY;
        active[`OSEQ_F_TR] = rs.state == oseq_pkg::ST_RUP;
        tripped = (rs.state == oseq_pkg::ST_OFF || rs.state == oseq_pkg::ST_FAULT) ? 5'h00
                  : fault_cond & active & enabled;
        // ramp-down time uses the fall divisor even before the ramp-down state is reached
        ramp_t = 17'(rs.ramp) * 17'(rs.trk[15:8]) + 17'(rs.cnt);

        // write channel: address and data taken in either order
        if (awvalid && rs.awready) begin
            nx.aw_idx = awaddr[6:2];
            nx.aw_map = mapped(awaddr[6:2]) && awaddr[7] == 1'b0;
            nx.aw_full = 1'b1;
        end
        if (wvalid && rs.wready) begin
            nx.wdat = wdata;
            nx.wstb = wstrb;
            nx.w_full = 1'b1;
        end
        if (rs.bvalid && bready) begin
            nx.bvalid = 1'b0;
        end
        if (rs.aw_full && rs.w_full && !rs.bvalid) begin
            nx.aw_full = 1'b0;
            nx.w_full = 1'b0;
            nx.bvalid = 1'b1;
            nx.bresp = rs.aw_map ? 2'b00 : 2'b10;
            if (rs.aw_map) begin
                case (rs.aw_idx)
                    `OSEQ_IDX_PROT: begin mrg = merge(32'(rs.prot), rs.wdat, rs.wstb); nx.prot = mrg[9:0]; end
                    `OSEQ_IDX_THR: begin mrg = merge(32'(rs.thr), rs.wdat, rs.wstb); nx.thr = mrg[16:0]; end
                    `OSEQ_IDX_TRK: begin mrg = merge(32'(rs.trk), rs.wdat, rs.wstb); nx.trk = mrg[15:0]; end
                    `OSEQ_IDX_DON: begin mrg = merge(32'(rs.turn_on_delay_reg), rs.wdat, rs.wstb); nx.turn_on_delay_reg = mrg[15:0]; end
                    `OSEQ_IDX_DOF: begin mrg = merge(32'(rs.turn_off_delay_reg), rs.wdat, rs.wstb); nx.turn_off_delay_reg = mrg[15:0]; end
                    `OSEQ_IDX_VOS: begin
                        mrg = merge(32'(rs.output_setpoint_reg), rs.wdat, rs.wstb);
                        nx.output_setpoint_reg = quant(mrg[8:0]);
                    end
                    `OSEQ_IDX_CLS: begin mrg = merge(32'(rs.current_limit_reg), rs.wdat, rs.wstb); nx.current_limit_reg = mrg[15:0]; end
                    `OSEQ_IDX_DCL: begin
                        mrg = merge(32'(rs.dcl), rs.wdat, rs.wstb);
                        if (rs.state == oseq_pkg::ST_OFF) begin
                            nx.dcl = mrg[7:0];
                        end
                    end
                    `OSEQ_IDX_RUN: begin
                        if (rs.wstb[0]) begin
                            nx.run = rs.wdat[0];
                        end
                    end
                    `OSEQ_IDX_ST: begin
                        if (rs.wstb[0]) begin
                            nx.st[4:0] = rs.st[4:0] | rs.wdat[4:0]; // writing one restores a tripped flag
                        end
                    end
                    default: begin
                        mrg = 32'h0;
                    end
                endcase
            end
        end
        nx.awready = !nx.aw_full && !nx.bvalid;
        nx.wready = !nx.w_full && !nx.bvalid;

        // read channel: one read under way, answer one cycle after the address
        if (arvalid && rs.arready) begin
            nx.arready = 1'b0;
            nx.rvalid = 1'b1;
            nx.rresp = 2'b00;
            case (araddr[7:2])
                {1'b0, `OSEQ_IDX_PROT}: nx.rdata = 32'(rs.prot);
                {1'b0, `OSEQ_IDX_THR}: nx.rdata = 32'(rs.thr);
                {1'b0, `OSEQ_IDX_TRK}: nx.rdata = 32'(rs.trk);
                {1'b0, `OSEQ_IDX_DON}: nx.rdata = 32'(rs.turn_on_delay_reg);
                {1'b0, `OSEQ_IDX_DOF}: nx.rdata = 32'(rs.turn_off_delay_reg);
                {1'b0, `OSEQ_IDX_VOS}: nx.rdata = 32'(rs.output_setpoint_reg);
                {1'b0, `OSEQ_IDX_CLS}: nx.rdata = 32'(rs.current_limit_reg);
                {1'b0, `OSEQ_IDX_DCL}: nx.rdata = 32'(rs.dcl);
                {1'b0, `OSEQ_IDX_RUN}: nx.rdata = {24'h0, rs.state, rs.run};
                {1'b0, `OSEQ_IDX_ST}: nx.rdata = 32'(rs.st);
                default: begin
                    nx.rdata = 32'h0;
                    nx.rresp = 2'b10;
                end
            endcase
        end else if (rs.rvalid && rready) begin
            nx.rvalid = 1'b0;
            nx.arready = 1'b1;
        end

        // sequencer; delays count master clock ticks
        case (rs.state)
            oseq_pkg::ST_OFF: begin
                nx.sw_en = 1'b0;
                nx.ramp = 9'h000;
                if (rs.run) begin
                    nx.state = oseq_pkg::ST_ON_DLY;
                    nx.cnt = 16'h0000;
                end
            end
            oseq_pkg::ST_ON_DLY: begin
                if (!rs.run) begin
                    nx.state = oseq_pkg::ST_OFF;
                end else if (rs.cnt >= rs.turn_on_delay_reg) begin
                    nx.state = oseq_pkg::ST_RUP;
                    nx.sw_en = 1'b1;
                end else if (master_tick) begin
                    nx.cnt = rs.cnt + 16'h0001;
                end
            end
            oseq_pkg::ST_RUP: begin
                if (!rs.run) begin
                    nx.state = oseq_pkg::ST_OFF_DL;
                    nx.cnt = 16'h0000;
                end else if (rs.ramp >= rs.output_setpoint_reg) begin
                    nx.state = oseq_pkg::ST_STEADY;
                end else if (step) begin
                    nx.ramp = rs.ramp + 9'h001;
                end
            end
            oseq_pkg::ST_STEADY: begin
                nx.ramp = rs.output_setpoint_reg;
                if (!rs.run) begin
                    nx.state = oseq_pkg::ST_OFF_DL;
                    nx.cnt = 16'h0000;
                end
            end
            oseq_pkg::ST_OFF_DL: begin
                if (rs.trk[15:8] != 8'h00) begin
                    // wait so the ramp-down finishes as the delay runs out
                    if (ramp_t >= 17'(rs.turn_off_delay_reg)) begin
                        nx.state = oseq_pkg::ST_RDN;
                    end else if (master_tick) begin
                        nx.cnt = rs.cnt + 16'h0001;
                    end
                end else if (rs.cnt >= rs.turn_off_delay_reg) begin
                    nx.state = oseq_pkg::ST_OFF;
                    nx.sw_en = 1'b0;
                    nx.ramp = 9'h000;
                end else if (master_tick) begin
                    nx.cnt = rs.cnt + 16'h0001;
                end
            end
            oseq_pkg::ST_RDN: begin
                if (rs.ramp == 9'h000) begin
                    nx.state = oseq_pkg::ST_OFF;
                    nx.sw_en = 1'b0;
                end else if (step) begin
                    nx.ramp = rs.ramp - 9'h001;
                end
            end
            oseq_pkg::ST_FAULT: begin
                nx.sw_en = 1'b0;
                nx.ramp = 9'h000;
                if (!rs.run) begin
                    nx.cyc = 1'b1;
                end
                if (rs.rst_cnt != RST_LAST) begin
                    nx.rst_cnt = rs.rst_cnt + 22'h000001;
                end else if ((fault_cond & rs.trip) != 5'h00) begin
                    nx.rst_cnt = (rs.trip & ~nonlat) == 5'h00 ? 22'h000000 : rs.rst_cnt;
                end else if (rs.run && ((rs.trip & ~nonlat) == 5'h00 || (rs.st[4:0] & rs.trip) == rs.trip
                                         || rs.cyc)) begin
                    nx.state = oseq_pkg::ST_ON_DLY;
                    nx.cnt = 16'h0000;
                    nx.trip = 5'h00;
                    nx.ls_on = 1'b0;
                end
            end
            default: begin
                nx.state = oseq_pkg::ST_OFF;
            end
        endcase

        // a trip beats any software restore in the same cycle
        if (tripped != 5'h00) begin
            nx.state = oseq_pkg::ST_FAULT;
            nx.trip = tripped;
            nx.st[4:0] = rs.st[4:0] & ~tripped;
            nx.rst_cnt = 22'h000000;
            nx.cyc = 1'b0;
            nx.sw_en = 1'b0;
            nx.ramp = 9'h000;
            nx.ls_on = tripped[`OSEQ_F_OV];
        end

        // warnings only flag, never touch the sequencer
        nx.st[`OSEQ_F_OTW] = !otw_cond;
        nx.st[`OSEQ_F_PG] = !(pg_cond || rs.state != oseq_pkg::ST_STEADY);
        nx.pg_ok = nx.st[`OSEQ_F_PG];

        // droop: output target falls with load current
        droop = 16'(iout) * 16'(rs.current_limit_reg[15:8]);
        nx.vout = (rs.ramp > 9'(droop[15:8])) ? rs.ramp - 9'(droop[15:8]) : 9'h000;

        // absolute levels in 0.125 mV units, following the live setpoint
        nx.ov_l = 17'(rs.output_setpoint_reg) * 17'(rs.thr[7:0]);
        nx.uv_l = 17'(rs.output_setpoint_reg) * 17'(rs.thr[15:8]);
        nx.pgh_l = 17'(rs.output_setpoint_reg) * 17'(`OSEQ_PGH_PCT);
        nx.pgl_l = 17'(rs.output_setpoint_reg) * 17'(rs.thr[16] ? `OSEQ_PGL_HI : `OSEQ_PGL_LO);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rs <= '0;
            rs.state <= oseq_pkg::ST_OFF;
            rs.output_setpoint_reg <= `OSEQ_RST_VOS;
            rs.current_limit_reg <= `OSEQ_RST_CLS;
            rs.prot <= `OSEQ_RST_PROT;
            rs.thr <= `OSEQ_RST_THR;
            rs.dcl <= `OSEQ_RST_DCL;
            rs.st <= `OSEQ_RST_ST;
            rs.arready <= 1'b1;
        end else if (clken) begin
            rs <= nx;
        end
    end

    assign awready = rs.awready;
    assign wready = rs.wready;
    assign bvalid = rs.bvalid;
    assign bresp = rs.bresp;
    assign arready = rs.arready;
    assign rvalid = rs.rvalid;
    assign rdata = rs.rdata;
    assign rresp = rs.rresp;
    assign vout_code = rs.vout;
    assign switch_en = rs.sw_en;
    assign low_side_on = rs.ls_on;
    assign power_good = rs.pg_ok;
    assign ov_level = rs.ov_l;
    assign uv_level = rs.uv_l;
    assign pgh_level = rs.pgh_l;
    assign pgl_level = rs.pgl_l;
    assign oc_limit = rs.current_limit_reg[7:0];
    assign duty_limit = rs.dcl;

    // ***********************************************************
    // assertions
    // ***********************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !clken);

    sequence s_trip;
        tripped != 5'h00;
    endsequence
    sequence s_rup_step;
        rs.state == oseq_pkg::ST_RUP && rs.run && step && rs.ramp < rs.output_setpoint_reg && tripped == 5'h00;
    endsequence

    vos_quant_a: assert property (rs.output_setpoint_reg >= `OSEQ_VOS_MIN && rs.output_setpoint_reg <= `OSEQ_VOS_MAX &&
        (rs.output_setpoint_reg <= `OSEQ_VOS_MID || !rs.output_setpoint_reg[0]) && (rs.output_setpoint_reg < `OSEQ_VOS_TOP || rs.output_setpoint_reg[1:0] == 2'b00))
        else $error("setpoint off its sub-range grid");
    ondly_off_a: assert property (rs.state == oseq_pkg::ST_ON_DLY |-> !rs.sw_en)
        else $error("switches on during turn-on delay");
    fall_zero_a: assert property (rs.state == oseq_pkg::ST_RDN && rs.ramp == 9'h000 && !(|tripped)
        |=> rs.state == oseq_pkg::ST_OFF && !rs.sw_en)
        else $error("ramp-down end did not stop output");
    nofall_off_a: assert property (rs.state == oseq_pkg::ST_OFF_DL && rs.trk[15:8] == 8'h00
        && rs.cnt >= rs.turn_off_delay_reg && !(|tripped) |=> !rs.sw_en ##1 rs.vout == 9'h000)
        else $error("switches not off at delay end");
    step_size_a: assert property (s_rup_step |=> rs.ramp == $past(rs.ramp) + 9'h001)
        else $error("ramp step not one code");
    step_tick_a: assert property (step |-> $past(master_tick))
        else $error("ramp step without master tick");
    trip_flag_a: assert property (s_trip |=> rs.state == oseq_pkg::ST_FAULT
        && (rs.st[4:0] & $past(tripped)) == 5'h00)
        else $error("trip not flagged");
    level_track_a: assert property ($changed(rs.output_setpoint_reg) |=> rs.ov_l == 17'($past(rs.output_setpoint_reg)) * 17'($past(rs.thr[7:0])))
        else $error("overvoltage level not tracking setpoint");
    restart_wait_a: assert property (rs.state == oseq_pkg::ST_FAULT && rs.rst_cnt != RST_LAST
        |=> rs.state == oseq_pkg::ST_FAULT)
        else $error("restart before interval");
    warn_keep_a: assert property (rs.state == oseq_pkg::ST_STEADY && rs.run && !(|tripped)
        |=> rs.state == oseq_pkg::ST_STEADY)
        else $error("warning left steady state");
    dcl_lock_a: assert property ($changed(rs.dcl) |-> $past(rs.state) == oseq_pkg::ST_OFF)
        else $error("duty limit changed while on");
endmodule
`default_nettype wire

// ---- test/oseq_tick_gen.sv ----
// master clock tick source standing in for the power manager
`timescale 1ns/1ps
`default_nettype none
module oseq_tick_gen #(
    parameter int DIV = 4
) (
    input  wire logic aclk,
    input  wire logic aresetn,
    output logic      master_tick
);
    logic [7:0] cnt_reg;
    // one-cycle tick every DIV clocks; all converters share it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg     <= 8'h00;
            master_tick <= 1'b0;
        end else begin
            cnt_reg     <= (cnt_reg == 8'(DIV - 1)) ? 8'h00 : cnt_reg + 8'h01;
            master_tick <= (cnt_reg == 8'(DIV - 1));
        end
    end
endmodule
`default_nettype wire

// ---- test/output_sequencing_protection_tb_top.sv ----
// register level test of the output sequencer
`timescale 1ns/1ps
`default_nettype none
module output_sequencing_protection_tb_top;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic tick, sw, pg, otw;
    logic [16:0] ovl;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp;
    logic [4:0] fault_cond;
    logic [8:0] vout;
    int fails, check_count;
    oseq_tick_gen oseq_tick_gen_inst (.aclk(aclk), .aresetn(aresetn), .master_tick(tick));
    oseq_core #(.RESTART_CYC(50)) oseq_core_inst (.aclk(aclk), .aresetn(aresetn), .clken(1'b1),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .master_tick(tick),
        .fault_cond(fault_cond), .otw_cond(otw), .pg_cond(1'b0), .iout(8'h00), .vout_code(vout),
        .switch_en(sw), .low_side_on(), .power_good(pg), .ov_level(ovl), .uv_level(), .pgh_level(),
        .pgl_level(), .oc_limit(), .duty_limit());
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task test_done;
        $display("mismatches %0d of %0d checks", fails, check_count);
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // both channels offered together, each released when taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            // bready stays high, so a following call never lowers and raises it in one step
            if (bvalid) begin
                return;
            end
        end
        fails++;
        test_done;
    endtask
    task rdr(input logic [7:0] a);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd = rdata;
                return;
            end
        end
        fails++;
        test_done;
    endtask
    // bounded wait for the ramp to reach a code
    task wv(input logic [8:0] v);
        for (int n = 0; n < 3000; n++) begin
            if (vout === v) return;
            @(posedge aclk);
        end
        fails++;
        test_done;
    endtask
    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; fault_cond = 5'h00; otw = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(8'h00); chk(rd, 32'h2AA);
        rdr(8'h20); chk(rd, 32'hFF);
        rdr(8'h80); chk(32'(rresp), 32'h2);
        // overvoltage level is setpoint code times 115 percent; margining is not modelled
        wr(8'h1C, 32'h010); rdr(8'h1C); chk(rd, 32'h028); chk(32'(ovl), 32'h11F8);
        wr(8'h1C, 32'h1FF); rdr(8'h1C); chk(rd, 32'h1B8); chk(32'(ovl), 32'hC5A8);
        // no load current and the fastest rise, one step per tick; inrush against the current limit is not checked
        wr(8'h1C, 32'h028); wr(8'h0C, 32'h1); wr(8'h14, 32'h4); wr(8'h18, 32'h4);
        wr(8'h54, 32'h1); chk(32'(vout), 32'h0);
        wv(9'h028);
        rdr(8'h54); chk(rd, 32'h11);
        fault_cond <= 5'h04;
        repeat (3) @(posedge aclk);
        chk(32'(sw), 32'h0);
        rdr(8'h58); chk(32'(rd[2]), 32'h0);
        fault_cond <= 5'h00;
        wv(9'h028);
        wr(8'h54, 32'h0);
        repeat (40) @(posedge aclk);
        chk(32'(sw), 32'h0);
        rdr(8'h54); chk(rd, 32'h02);
        // two ticks a fall step: 80 ticks of ramp-down inside a 96 tick delay
        wr(8'h0C, 32'h0201); wr(8'h18, 32'h60); wr(8'h54, 32'h1); wv(9'h028);
        wr(8'h54, 32'h0);
        repeat (200) @(posedge aclk);
        chk(32'(sw), 32'h1); chk(32'(vout != 9'h000), 32'h1);
        // the whole delay is 384 clocks, ramp-down included
        repeat (200) @(posedge aclk);
        chk(32'(vout), 32'h0); chk(32'(sw), 32'h0);
        // overtemperature made latching: stays off until its flag is restored
        wr(8'h00, 32'h29A); wr(8'h54, 32'h1); wv(9'h028);
        fault_cond <= 5'h04;
        repeat (3) @(posedge aclk);
        fault_cond <= 5'h00;
        repeat (100) @(posedge aclk);
        rdr(8'h54); chk(rd, 32'h81); chk(32'(sw), 32'h0);
        wr(8'h58, 32'h04); wv(9'h028);
        otw <= 1'b1;
        repeat (3) @(posedge aclk);
        rdr(8'h58); chk(32'(rd[5]), 32'h0);
        rdr(8'h54); chk(rd, 32'h11); chk(32'(sw), 32'h1);
        otw <= 1'b0;
        test_done;
    end
endmodule
`default_nettype wire
